/* File: shared/alm_pkg.sv */
// Package with the register map, fields and types of the layer-4 matcher.
package alm_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int ALM_AW = 8;
	localparam int ALM_DW = 32;
	localparam logic [7:0] ALM_REG_CTRL = 8'h00;
	localparam logic [7:0] ALM_REG_ICMP = 8'h04;
	localparam logic [7:0] ALM_REG_SPORT = 8'h08;
	localparam logic [7:0] ALM_REG_DPORT = 8'h0c;
	localparam logic [7:0] ALM_REG_FLAGS = 8'h10;
	localparam logic [7:0] ALM_REG_HITCNT = 8'h14;
	localparam logic [7:0] ALM_REG_FRMCNT = 8'h18;
	localparam logic [7:0] ALM_REG_LAST = 8'h1c;

	// ****************************************
	// Field layouts and reset values
	// ****************************************
	localparam int ALM_CTRL_W = 8;
	localparam int ALM_CTRL_PROTO = 0;
	localparam int ALM_CTRL_TSPEC = 2;
	localparam int ALM_CTRL_CSPEC = 3;
	localparam int ALM_CTRL_SMODE = 4;
	localparam int ALM_CTRL_DMODE = 6;
	localparam logic [7:0] ALM_CTRL_RST = 8'h00;
	localparam int ALM_ICMP_TYPE = 0;
	localparam int ALM_ICMP_CODE = 8;
	localparam logic [15:0] ALM_ICMP_RST = 16'h0000;
	localparam int ALM_PORT_LO = 0;
	localparam int ALM_PORT_HI = 16;
	localparam logic [31:0] ALM_PORT_RST = 32'hffff0000;
	localparam int ALM_NFLAGS = 6;
	localparam logic [11:0] ALM_FLAGS_RST = 12'haaa;
	localparam logic [7:0] ALM_IPPROTO_ICMP = 8'h01;
	localparam logic [7:0] ALM_IPPROTO_TCP = 8'h06;
	localparam logic [7:0] ALM_IPPROTO_UDP = 8'h11;
	localparam int ALM_LATENCY = 2;

	// Positions of the per-criterion verdicts in the stage-one vector.
	localparam int ALM_OK_PROTO = 0;
	localparam int ALM_OK_TYPE = 1;
	localparam int ALM_OK_CODE = 2;
	localparam int ALM_OK_SRC = 3;
	localparam int ALM_OK_DST = 4;
	localparam int ALM_OK_FLAG = 5;
	localparam int ALM_OK_W = 11;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		ALM_PROTO_ANY = 2'b00,
		ALM_PROTO_ICMP = 2'b01,
		ALM_PROTO_TCP = 2'b10,
		ALM_PROTO_UDP = 2'b11
	} alm_proto_e;

	typedef enum logic [1:0] {
		ALM_PORT_ANY = 2'b00,
		ALM_PORT_SPEC = 2'b01,
		ALM_PORT_RANGE = 2'b10,
		ALM_PORT_RSVD = 2'b11
	} alm_pmode_e;

	typedef enum logic [1:0] {
		ALM_FLAG_ZERO = 2'b00,
		ALM_FLAG_ONE = 2'b01,
		ALM_FLAG_ANY = 2'b10,
		ALM_FLAG_ANY2 = 2'b11
	} alm_fmode_e;

	// Parsed header fields of one frame; flag bit 0 is FIN up to bit 5 URG.
	typedef struct packed {
		logic valid;
		logic [7:0] ipProto;
		logic [7:0] icmpType;
		logic [7:0] icmpCode;
		logic [15:0] srcPort;
		logic [15:0] dstPort;
		logic [5:0] tcpFlags;
	} alm_frame_s;

	typedef struct packed {
		logic valid;
		logic hit;
	} alm_result_s;

endpackage : alm_pkg

/* File: rtl/alm_l4_matcher.sv */
// Layer-4 matcher of one access_control_entry: ICMP, ports and TCP flags.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

// What this block does
// [RULE_01] ICMP type any never blocks a hit.
// [RULE_02] Specific ICMP type must equal configured byte.
// [RULE_03] ICMP code any is ignored.
// [RULE_04] Specific ICMP code compared for equality.
// [RULE_05] Source port any never influences result.
// [RULE_06] Specific source port must equal value.
// [RULE_07] Source port range must contain frame port.
// [RULE_08] Destination port any is don't-care.
// [RULE_09] Specific destination port must equal value.
// [RULE_10] Destination range must contain frame port.
// [RULE_11] FIN criterion: zero, one or any.
// [RULE_12] SYN criterion: zero, one or any.
// [RULE_13] RST criterion: zero, one or any.
// [RULE_14] PSH criterion: zero, one or any.
// [RULE_15] ACK criterion: zero, one or any.
// [RULE_16] URG criterion: zero, one or any.
// [RULE_17] ICMP criteria apply to ICMP entries only.
// [RULE_18] Ports for TCP/UDP entries, flags TCP only.
// [RULE_19] Hit only when all criteria match together.
// [RULE_20] Inclusive ranges, fixed two-cycle result latency.
module alm_l4_matcher
	import alm_pkg::*;
(
	input logic clk,
	input logic nrst,
	input logic [ALM_AW-1:0] regAddr,
	input logic [ALM_DW-1:0] regWdata,
	input logic regWr,
	input logic regRd,
	output logic [ALM_DW-1:0] regRdata,
	input alm_frame_s frame,
	output alm_result_s result
);

	// ****************************************
	// Configuration and status registers
	// ****************************************
	logic [ALM_CTRL_W-1:0] ctrl_q;
	logic [15:0] icmp_q;
	logic [31:0] sport_q;
	logic [31:0] dport_q;
	logic [11:0] flags_q;
	logic [31:0] hitCnt_q;
	logic [31:0] frmCnt_q;
	logic lastHit_q;
	logic seen_q;
	logic [ALM_DW-1:0] rdata_q;

	// Write strobes per register.
	wire wrCtrl = regWr && (regAddr == ALM_REG_CTRL);
	wire wrIcmp = regWr && (regAddr == ALM_REG_ICMP);
	wire wrSport = regWr && (regAddr == ALM_REG_SPORT);
	wire wrDport = regWr && (regAddr == ALM_REG_DPORT);
	wire wrFlags = regWr && (regAddr == ALM_REG_FLAGS);
	wire wrHitCnt = regWr && (regAddr == ALM_REG_HITCNT);
	wire wrFrmCnt = regWr && (regAddr == ALM_REG_FRMCNT);

	// Settings are taken in one cycle; a frame in that cycle still sees the old entry.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_q <= ALM_CTRL_RST;
			icmp_q <= ALM_ICMP_RST;
			sport_q <= ALM_PORT_RST;
			dport_q <= ALM_PORT_RST;
			flags_q <= ALM_FLAGS_RST;
		end
		else
		begin
			if (wrCtrl)
				ctrl_q <= regWdata[ALM_CTRL_W-1:0];
			if (wrIcmp)
				icmp_q <= regWdata[15:0];
			if (wrSport)
				sport_q <= regWdata;
			if (wrDport)
				dport_q <= regWdata;
			if (wrFlags)
				flags_q <= regWdata[11:0];
		end
	end

	// ****************************************
	// Field decode
	// ****************************************
	wire alm_proto_e entryProto = alm_proto_e'(ctrl_q[ALM_CTRL_PROTO +: 2]);
	wire typeSpec = ctrl_q[ALM_CTRL_TSPEC];
	wire codeSpec = ctrl_q[ALM_CTRL_CSPEC];
	wire alm_pmode_e srcMode = alm_pmode_e'(ctrl_q[ALM_CTRL_SMODE +: 2]);
	wire alm_pmode_e dstMode = alm_pmode_e'(ctrl_q[ALM_CTRL_DMODE +: 2]);
	wire [7:0] cfgType = icmp_q[ALM_ICMP_TYPE +: 8];
	wire [7:0] cfgCode = icmp_q[ALM_ICMP_CODE +: 8];
	wire [15:0] srcLo = sport_q[ALM_PORT_LO +: 16];
	wire [15:0] srcHi = sport_q[ALM_PORT_HI +: 16];
	wire [15:0] dstLo = dport_q[ALM_PORT_LO +: 16];
	wire [15:0] dstHi = dport_q[ALM_PORT_HI +: 16];
	wire entryIcmp = (entryProto == ALM_PROTO_ICMP);
	wire entryTcp = (entryProto == ALM_PROTO_TCP);
	wire entryL4 = entryTcp || (entryProto == ALM_PROTO_UDP);

	// A port verdict; the reserved mode behaves as any.
	function automatic logic portOk(
		input alm_pmode_e mode,
		input logic [15:0] port,
		input logic [15:0] lo,
		input logic [15:0] hi
	);
		logic ok;
		ok = 1'b1;
		case (mode)
			ALM_PORT_SPEC: ok = (port == lo);
			ALM_PORT_RANGE: ok = (port >= lo) && (port <= hi);
			default: ok = 1'b1;
		endcase
		return ok;
	endfunction : portOk

	// ****************************************
	// Stage one: per-criterion verdicts
	// ****************************************
	logic [ALM_OK_W-1:0] ok;
	logic [ALM_OK_W-1:0] okVec_q;
	logic valid1_q;

	// [RULE_17] protocol gating
	// A non-any entry only takes frames of its own IP protocol.
	assign ok[ALM_OK_PROTO] = (entryProto == ALM_PROTO_ANY)
		|| (entryIcmp && frame.ipProto == ALM_IPPROTO_ICMP)
		|| (entryTcp && frame.ipProto == ALM_IPPROTO_TCP)
		|| (entryProto == ALM_PROTO_UDP && frame.ipProto == ALM_IPPROTO_UDP);
	// [RULE_01] type any
	// [RULE_02] type equality
	assign ok[ALM_OK_TYPE] = !entryIcmp || !typeSpec || (frame.icmpType == cfgType);
	// [RULE_03] code any
	// [RULE_04] code equality
	assign ok[ALM_OK_CODE] = !entryIcmp || !codeSpec || (frame.icmpCode == cfgCode);
	// [RULE_05] source any
	// [RULE_06] source exact
	// [RULE_07] source range
	// [RULE_18] ports when L4
	assign ok[ALM_OK_SRC] = !entryL4 || portOk(srcMode, frame.srcPort, srcLo, srcHi);
	// [RULE_08] destination any
	// [RULE_09] destination exact
	// [RULE_10] destination range
	// [RULE_20] inclusive bounds
	assign ok[ALM_OK_DST] = !entryL4 || portOk(dstMode, frame.dstPort, dstLo, dstHi);

	// [RULE_11] FIN three-valued
	// [RULE_12] SYN three-valued
	// [RULE_13] RST three-valued
	// [RULE_14] PSH three-valued
	// [RULE_15] ACK three-valued
	// [RULE_16] URG three-valued
	// [RULE_18] flags TCP only
	// Mode bit 1 set means any; otherwise the frame bit must equal mode bit 0.
	for (genvar i = 0; i < ALM_NFLAGS; i++)
	begin : g_flag
		wire [1:0] fmode = flags_q[2*i +: 2];
		assign ok[ALM_OK_FLAG+i] = !entryTcp || fmode[1] || (frame.tcpFlags[i] == fmode[0]);
	end

	// Stage-one registers break the compare path from the final AND.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			valid1_q <= 1'b0;
			okVec_q <= '0;
		end
		else
		begin
			valid1_q <= frame.valid;
			okVec_q <= ok;
		end
	end

	// ****************************************
	// Stage two: combined verdict
	// ****************************************
	// [RULE_19] all criteria together
	wire hitNow = valid1_q && (&okVec_q);
	alm_result_s result_q;

	// [RULE_20] fixed latency
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			result_q <= '0;
		else
		begin
			result_q.valid <= valid1_q;
			result_q.hit <= hitNow;
		end
	end
	assign result = result_q;

	// ****************************************
	// Status counters and read port
	// ****************************************
	// A write clears a counter; an event in the same cycle wins and leaves one.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			hitCnt_q <= '0;
			frmCnt_q <= '0;
			lastHit_q <= 1'b0;
			seen_q <= 1'b0;
		end
		else
		begin
			if (wrHitCnt)
				hitCnt_q <= {31'h0, hitNow};
			else if (hitNow)
				hitCnt_q <= hitCnt_q + 32'h1;
			if (wrFrmCnt)
				frmCnt_q <= {31'h0, valid1_q};
			else if (valid1_q)
				frmCnt_q <= frmCnt_q + 32'h1;
			if (valid1_q)
			begin
				lastHit_q <= &okVec_q;
				seen_q <= 1'b1;
			end
		end
	end

	// Read selection; unmapped addresses read as zero.
	wire [ALM_DW-1:0] rdMux =
		(regAddr == ALM_REG_CTRL) ? {24'h0, ctrl_q} :
		(regAddr == ALM_REG_ICMP) ? {16'h0, icmp_q} :
		(regAddr == ALM_REG_SPORT) ? sport_q :
		(regAddr == ALM_REG_DPORT) ? dport_q :
		(regAddr == ALM_REG_FLAGS) ? {20'h0, flags_q} :
		(regAddr == ALM_REG_HITCNT) ? hitCnt_q :
		(regAddr == ALM_REG_FRMCNT) ? frmCnt_q :
		(regAddr == ALM_REG_LAST) ? {30'h0, seen_q, lastHit_q} :
		32'h0;

	// Read data stands only in the cycle after the strobe.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rdata_q <= '0;
		else
			rdata_q <= regRd ? rdMux : '0;
	end
	assign regRdata = rdata_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cbChk @(posedge clk);
	endclocking
	default disable iff (!nrst);

	wire icmpFrm = frame.valid && entryIcmp && frame.ipProto == ALM_IPPROTO_ICMP;
	wire l4Frm = frame.valid && entryL4 && ok[ALM_OK_PROTO];

	// [RULE_01] type any
	chk_type_any : assert property ( // [RULE_01]
		icmpFrm && !typeSpec |=> okVec_q[ALM_OK_TYPE])
		else $error("ICMP type any blocked a frame.");
	// [RULE_02] type mismatch
	chk_type_miss : assert property ( // [RULE_02]
		icmpFrm && typeSpec && frame.icmpType != cfgType |-> ##2 result.valid && !result.hit)
		else $error("ICMP type mismatch gave a hit.");
	// [RULE_03] code any
	chk_code_any : assert property ( // [RULE_03]
		icmpFrm && !codeSpec |=> okVec_q[ALM_OK_CODE])
		else $error("ICMP code any blocked a frame.");
	// [RULE_04] code mismatch
	chk_code_miss : assert property ( // [RULE_04]
		icmpFrm && codeSpec && frame.icmpCode != cfgCode |-> ##2 result.valid && !result.hit)
		else $error("ICMP code mismatch gave a hit.");
	// [RULE_05] source any
	chk_src_any : assert property ( // [RULE_05]
		frame.valid && srcMode == ALM_PORT_ANY |=> okVec_q[ALM_OK_SRC])
		else $error("Source any blocked a frame.");
	// [RULE_06] source exact
	chk_src_exact : assert property ( // [RULE_06]
		l4Frm && srcMode == ALM_PORT_SPEC |=> okVec_q[ALM_OK_SRC] == $past(frame.srcPort == srcLo))
		else $error("Source exact verdict wrong.");
	// [RULE_07] source range
	chk_src_range : assert property ( // [RULE_07]
		l4Frm && srcMode == ALM_PORT_RANGE && (frame.srcPort < srcLo || frame.srcPort > srcHi)
		|-> ##2 result.valid && !result.hit)
		else $error("Source outside range gave a hit.");
	// [RULE_08] destination any
	chk_dst_any : assert property ( // [RULE_08]
		frame.valid && dstMode == ALM_PORT_ANY |=> okVec_q[ALM_OK_DST])
		else $error("Destination any blocked a frame.");
	// [RULE_09] destination exact
	chk_dst_exact : assert property ( // [RULE_09]
		l4Frm && dstMode == ALM_PORT_SPEC && frame.dstPort != dstLo |-> ##2 !result.hit)
		else $error("Destination mismatch gave a hit.");
	// [RULE_10] destination range
	chk_dst_range : assert property ( // [RULE_10]
		l4Frm && dstMode == ALM_PORT_RANGE && (frame.dstPort == dstLo || frame.dstPort == dstHi)
		&& dstLo <= dstHi |=> okVec_q[ALM_OK_DST])
		else $error("Destination bound not inclusive.");

	// [RULE_11] FIN to URG checks
	// [RULE_16] URG included
	for (genvar j = 0; j < ALM_NFLAGS; j++)
	begin : g_flag_chk
		wire [1:0] cm = flags_q[2*j +: 2];
		chk_flag_zero : assert property ( // [RULE_11]
			l4Frm && entryTcp && cm == ALM_FLAG_ZERO && frame.tcpFlags[j]
			|-> ##2 result.valid && !result.hit)
			else $error("Flag set but entry wants it clear.");
		chk_flag_one : assert property ( // [RULE_12]
			l4Frm && entryTcp && cm == ALM_FLAG_ONE && !frame.tcpFlags[j] |-> ##2 !result.hit)
			else $error("Flag clear but entry wants it set.");
	end

	// [RULE_13] RST zero blocks
	chk_rst_flag : assert property ( // [RULE_13]
		l4Frm && entryTcp && flags_q[5:4] == ALM_FLAG_ZERO && frame.tcpFlags[2]
		|-> ##2 result.valid && !result.hit)
		else $error("RST set passed a zero criterion.");
	// [RULE_14] PSH any
	chk_psh_any : assert property ( // [RULE_14]
		frame.valid && flags_q[7] |=> okVec_q[ALM_OK_FLAG+3])
		else $error("PSH any blocked a frame.");
	// [RULE_15] ACK any
	chk_ack_any : assert property ( // [RULE_15]
		frame.valid && flags_q[9] |=> okVec_q[ALM_OK_FLAG+4])
		else $error("ACK any blocked a frame.");
	// [RULE_17] protocol gate
	chk_proto_gate : assert property ( // [RULE_17]
		frame.valid && !ok[ALM_OK_PROTO] |-> ##2 result.valid && !result.hit)
		else $error("Frame of another protocol hit.");
	// [RULE_18] UDP ignores flags
	chk_udp_flags : assert property ( // [RULE_18]
		frame.valid && entryProto == ALM_PROTO_UDP |=> &okVec_q[ALM_OK_W-1:ALM_OK_FLAG])
		else $error("Flags judged on a UDP entry.");
	// [RULE_19] hit needs all
	chk_hit_all : assert property ( // [RULE_19]
		result.hit |-> result.valid && $past(&okVec_q))
		else $error("Hit without every criterion.");
	// [RULE_20] fixed latency
	chk_latency : assert property ( // [RULE_20]
		frame.valid |-> ##1 valid1_q ##1 result.valid)
		else $error("Result not two cycles after frame.");
	chk_no_spurious : assert property ( // [RULE_20]
		!frame.valid |-> ##2 !result.valid)
		else $error("Result without a frame.");

endmodule : alm_l4_matcher

/* File: tb/alm_parser_model.sv */
// Model of the ingress parser that hands parsed frames to the matcher.
`timescale 1ns/1ps
module alm_parser_model
	import alm_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic send,
	input wire alm_frame_s req,
	output alm_frame_s frame
);
	// ****************
	// Frame driver
	// ****************
	// A frame stands one cycle; between frames the fields toggle, so stale data never matches.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			frame <= '0;
		else if (send)
			frame <= {1'b1, req[61:0]};
		else
			frame <= {1'b0, ~frame[61:0]};
	end
endmodule : alm_parser_model

/* File: tb/alm_l4_matcher_tb.sv */
// Self-checking testbench of the layer-4 matcher.
`timescale 1ns/1ps
module alm_l4_matcher_tb
	import alm_pkg::*;
;
	// ****************
	// Signals and design
	// ****************
	typedef struct {logic [31:0] val; int due;} alm_note_s;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [ALM_AW-1:0] regAddr = '0;
	logic [ALM_DW-1:0] regWdata = '0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [ALM_DW-1:0] regRdata;
	logic send = 1'b0;
	alm_frame_s req = '0;
	alm_frame_s frame;
	alm_frame_s f;
	alm_result_s result;
	alm_note_s hitQ[$];
	alm_note_s rdQ[$];
	alm_note_s nt;
	int cyc = 0;
	int mismatches = 0;
	int comparisons = 0;
	int nFrm = 0;
	int nHit = 0;
	logic lastExp = 1'b0;
	int dummy;
	logic [7:0] cCtrl;
	logic [15:0] cIcmp;
	logic [31:0] cSp;
	logic [31:0] cDp;
	logic [11:0] cFl;
	logic [11:0] fl;
	logic [15:0] lo;
	logic [15:0] hi;
	logic [15:0] pr [8];
	logic [7:0] tv;
	logic [7:0] cv;
	logic [63:0] rnd;

	// Clock and a free cycle count used to time every expected answer.
	always #5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	alm_l4_matcher uut (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .frame(frame), .result(result));
	alm_parser_model parser (.clk(clk), .nrst(nrst), .send(send), .req(req), .frame(frame));

	// ****************
	// Tasks
	// ****************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic end_sim;
		$display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim

	// A write also ends any frame burst, so config never changes under a queued frame.
	task automatic busWr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		send <= 1'b0;
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : busWr

	task automatic busRd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		send <= 1'b0;
		regRd <= 1'b1;
		regAddr <= a;
		rdQ.push_back('{e, cyc + 2});
		@(posedge clk);
		regRd <= 1'b0;
	endtask : busRd

	task automatic setCfg(input logic [7:0] c, input logic [15:0] ic, input logic [31:0] s,
		input logic [31:0] d, input logic [11:0] fv);
		cCtrl = c;
		cIcmp = ic;
		cSp = s;
		cDp = d;
		cFl = fv;
		busWr(ALM_REG_CTRL, {24'h0, c});
		busWr(ALM_REG_ICMP, {16'h0, ic});
		busWr(ALM_REG_SPORT, s);
		busWr(ALM_REG_DPORT, d);
		busWr(ALM_REG_FLAGS, {20'h0, fv});
	endtask : setCfg

	function automatic logic portOk(input logic [1:0] m, input logic [15:0] p,
		input logic [31:0] c);
		return (m == 2'd1) ? (p == c[15:0]) : (m == 2'd2) ? (p >= c[15:0] && p <= c[31:16]) : 1'b1;
	endfunction : portOk

	// Reference verdict from the shadow copy of the entry.
	function automatic logic expHit(input alm_frame_s x);
		logic ok;
		ok = 1'b1;
		if (cCtrl[1:0] == 2'd1)
			ok = x.ipProto == ALM_IPPROTO_ICMP && (!cCtrl[2] || x.icmpType == cIcmp[7:0])
				&& (!cCtrl[3] || x.icmpCode == cIcmp[15:8]);
		else if (cCtrl[1])
		begin
			ok = x.ipProto == (cCtrl[0] ? ALM_IPPROTO_UDP : ALM_IPPROTO_TCP)
				&& portOk(cCtrl[5:4], x.srcPort, cSp) && portOk(cCtrl[7:6], x.dstPort, cDp);
			for (int i = 0; i < ALM_NFLAGS; i++)
				if (!cCtrl[0] && !cFl[2*i+1] && x.tcpFlags[i] != cFl[2*i])
					ok = 1'b0;
		end
		return ok;
	endfunction : expHit

	function automatic alm_frame_s rndFrame(input int k);
		logic [63:0] r;
		r = {$urandom(), $urandom()};
		rndFrame = r[62:0];
		if (k < 3)
			rndFrame.ipProto = (k == 0) ? ALM_IPPROTO_ICMP : (k == 1) ? ALM_IPPROTO_TCP : ALM_IPPROTO_UDP;
	endfunction : rndFrame

	// Frames go out back to back; the parser model adds one cycle before the matcher.
	task automatic sendFrame(input alm_frame_s x);
		@(posedge clk);
		send <= 1'b1;
		req <= x;
		hitQ.push_back('{{31'h0, expHit(x)}, cyc + 2 + ALM_LATENCY});
		lastExp = expHit(x);
		nFrm++;
		nHit += int'(lastExp);
	endtask : sendFrame

	// Monitor: takes the oldest note whenever read data or a result is due.
	always @(posedge clk)
	begin
		if (rdQ.size() > 0 && rdQ[0].due == cyc)
		begin
			nt = rdQ.pop_front();
			check(regRdata, nt.val);
		end
		else if (nrst === 1'b1)
			check(regRdata, 32'h0);
		if (result.valid === 1'b1)
		begin
			nt = (hitQ.size() > 0) ? hitQ.pop_front() : alm_note_s'{32'h2, 0};
			check({31'h0, result.hit}, nt.val);
			check(cyc, nt.due);
		end
	end

	// Watchdog: the whole run needs some one thousand cycles.
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		end_sim;
	end

	// ****************
	// Tests
	// ****************
	initial
	begin
		cCtrl = ALM_CTRL_RST;
		cIcmp = ALM_ICMP_RST;
		cSp = ALM_PORT_RST;
		cDp = ALM_PORT_RST;
		cFl = ALM_FLAGS_RST;
		dummy = $urandom(294);
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		busRd(ALM_REG_CTRL, {24'h0, ALM_CTRL_RST});
		busRd(ALM_REG_SPORT, ALM_PORT_RST);
		busRd(ALM_REG_FLAGS, {20'h0, ALM_FLAGS_RST});
		busRd(8'h20, 32'h0);
		busRd(ALM_REG_HITCNT, 32'h0);
		busRd(ALM_REG_LAST, 32'h0);
		for (int n = 0; n < 16; n++)
			sendFrame(rndFrame(n % 4));
		$display("test registers and any-entry done");
		for (int k = 0; k < 8; k++)
		begin
			tv = k[2] ? 8'hff : 8'h00;
			cv = ~tv;
			setCfg({4'h0, k[1:0], 2'd1}, {cv, tv}, ALM_PORT_RST, ALM_PORT_RST, ALM_FLAGS_RST);
			for (int j = 0; j < 4; j++)
			begin
				f = rndFrame((j == 3) ? 1 : 0);
				f.icmpType = tv ^ {7'h0, j == 1};
				f.icmpCode = cv ^ {7'h0, j == 2};
				sendFrame(f);
			end
		end
		$display("test icmp done");
		for (int k = 0; k < 16; k++)
		begin
			lo = k[3] ? 16'h0000 : 16'(1 + $urandom_range(30000));
			hi = k[3] ? 16'hffff : lo + 16'($urandom_range(300));
			pr = '{lo - 16'h1, lo, lo + 16'h1, hi - 16'h1, hi, hi + 16'h1, 16'h0000, 16'hffff};
			setCfg(k[2] ? {k[1:0], 4'h0, 1'b1, k[0]} : {2'b00, k[1:0], 2'b00, 1'b1, k[3]},
				16'h0, {hi, lo}, {hi, lo}, ALM_FLAGS_RST);
			for (int j = 0; j < 8; j++)
			begin
				f = rndFrame(cCtrl[0] ? 2 : 1);
				if (k[2])
					f.dstPort = pr[j];
				else
					f.srcPort = pr[j];
				sendFrame(f);
			end
		end
		$display("test ports done");
		for (int k = 0; k < 24; k++)
		begin
			fl = ALM_FLAGS_RST;
			fl[2*(k/4) +: 2] = k[1:0];
			setCfg(8'h02, 16'h0, ALM_PORT_RST, ALM_PORT_RST, fl);
			for (int j = 0; j < 4; j++)
			begin
				f = rndFrame((j == 3) ? 2 : 1);
				f.tcpFlags[k/4] = j[0];
				sendFrame(f);
			end
		end
		setCfg(8'h03, 16'h0, ALM_PORT_RST, ALM_PORT_RST, 12'h000);
		f = rndFrame(2);
		f.tcpFlags = 6'h3f;
		sendFrame(f);
		$display("test tcp flags done");
		for (int k = 0; k < 10; k++)
		begin
			rnd = {$urandom(), $urandom()};
			setCfg(rnd[7:0], rnd[23:8], $urandom(), $urandom(), rnd[35:24]);
			for (int j = 0; j < 12; j++)
				sendFrame(rndFrame(j % 4));
		end
		busWr(ALM_REG_CTRL, 32'h0);
		repeat (8) @(posedge clk);
		// Counters must agree with the reference tally of every frame sent.
		busRd(ALM_REG_FRMCNT, nFrm);
		busRd(ALM_REG_HITCNT, nHit);
		busRd(ALM_REG_LAST, {30'h0, 1'b1, lastExp});
		busWr(ALM_REG_HITCNT, 32'h0);
		busRd(ALM_REG_HITCNT, 32'h0);
		repeat (4) @(posedge clk);
		check(hitQ.size(), 32'h0);
		check(rdQ.size(), 32'h0);
		$display("test random entries done");
		end_sim;
	end
endmodule : alm_l4_matcher_tb
